// [ifb_bank.sv]
// Interrupt request flag and enable bank with an AXI4-Lite register port.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ifb_bank
    import ifb_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [11:0] s_awaddr_in,
    input  wire logic        s_awvalid_in,
    output logic             s_awready_out,
    input  wire logic [31:0] s_wdata_in,
    input  wire logic [3:0]  s_wstrb_in,
    input  wire logic        s_wvalid_in,
    output logic             s_wready_out,
    output logic [1:0]       s_bresp_out,
    output logic             s_bvalid_out,
    input  wire logic        s_bready_in,
    input  wire logic [11:0] s_araddr_in,
    input  wire logic        s_arvalid_in,
    output logic             s_arready_out,
    output logic [31:0]      s_rdata_out,
    output logic [1:0]       s_rresp_out,
    output logic             s_rvalid_out,
    input  wire logic        s_rready_in,
    input  wire ifb_src_t    src_set_in,
    input  wire logic        core_ack_in,
    input  wire ifb_src_t    core_service_in,
    input  wire logic        stack_full_in,
    output ifb_src_t         irq_request_out,
    output logic             irq_pending_out,
    output logic             irq_taken_out,
    output logic             wake_out
);
    `include "ifb_map.svh"

    logic     [7:0] ctrl0_en;
    logic     [7:0] ctrl1_en;
    logic     [7:0] ctrl2_en;
    logic     [7:0] ctrl3_en;
    logic           global_irq_enable;
    ifb_src_t       flags;
    ifb_src_t       flags_q;
    ifb_src_t       sw_we;
    ifb_src_t       sw_val;
    ifb_src_t       gated;
    ifb_wr_t        wr;
    logic    [11:0] rd_addr;
    logic    [31:0] rd_data;
    logic           rd_hit;
    logic           wr_hit;

    // Pack the four control bytes from flags and enables.
    function automatic logic [7:0] pack_byte(input logic [3:0] f, input logic [3:0] e);
        pack_byte = {f, e};
    endfunction

    wire logic [7:0] ctrl0_val;
    wire logic [7:0] ctrl1_val;
    wire logic [7:0] ctrl2_val;
    wire logic [7:0] ctrl3_val;

    // Bit 7 of control 0 is unimplemented and always reads zero.
    assign ctrl0_val = pack_byte({1'b0, flags.ext_pin_b, flags.ext_pin_a,
                                  flags.comparator_a},
                                 {ctrl0_en[3:1], global_irq_enable}) & `IFB_CTRL0_WMASK;
    assign ctrl1_val = pack_byte({flags.eeprom, flags.adc, flags.low_voltage,
                                  flags.serial_module}, ctrl1_en[3:0]);
    assign ctrl2_val = pack_byte({flags.timer0_a, flags.timer0_p, flags.periodic_a,
                                  flags.periodic_p}, ctrl2_en[3:0]);
    assign ctrl3_val = pack_byte({flags.combined, flags.comparator_b, flags.timebase_b,
                                  flags.timebase_a}, ctrl3_en[3:0]);

    wire logic wr0;
    wire logic wr1;
    wire logic wr2;
    wire logic wr3;
    assign wr0 = wr.valid && (wr.index == 2'd0);
    assign wr1 = wr.valid && (wr.index == 2'd1);
    assign wr2 = wr.valid && (wr.index == 2'd2);
    assign wr3 = wr.valid && (wr.index == 2'd3);

    // Software flag writes, one field per source.
    assign sw_we.ext_pin_b     = wr0;
    assign sw_we.ext_pin_a     = wr0;
    assign sw_we.comparator_a  = wr0;
    assign sw_we.eeprom        = wr1;
    assign sw_we.adc           = wr1;
    assign sw_we.low_voltage   = wr1;
    assign sw_we.serial_module = wr1;
    assign sw_we.timer0_a      = wr2;
    assign sw_we.timer0_p      = wr2;
    assign sw_we.periodic_a    = wr2;
    assign sw_we.periodic_p    = wr2;
    assign sw_we.combined      = wr3;
    assign sw_we.comparator_b  = wr3;
    assign sw_we.timebase_b    = wr3;
    assign sw_we.timebase_a    = wr3;

    assign sw_val.ext_pin_b     = wr.data[6];
    assign sw_val.ext_pin_a     = wr.data[5];
    assign sw_val.comparator_a  = wr.data[4];
    assign sw_val.eeprom        = wr.data[7];
    assign sw_val.adc           = wr.data[6];
    assign sw_val.low_voltage   = wr.data[5];
    assign sw_val.serial_module = wr.data[4];
    assign sw_val.timer0_a      = wr.data[7];
    assign sw_val.timer0_p      = wr.data[6];
    assign sw_val.periodic_a    = wr.data[5];
    assign sw_val.periodic_p    = wr.data[4];
    assign sw_val.combined      = wr.data[7];
    assign sw_val.comparator_b  = wr.data[6];
    assign sw_val.timebase_b    = wr.data[5];
    assign sw_val.timebase_a    = wr.data[4];

    genvar gi;
    generate
        for (gi = 0; gi < $bits(ifb_src_t); gi++) begin : g_flag
            ifb_flag_cell u_cell (
                .clk_in           (clk_in),
                .rst_in           (rst_in),
                .set_in           (src_set_in[gi]),
                .sw_write_in      (sw_we[gi]),
                .sw_value_in      (sw_val[gi]),
                .service_clear_in (core_service_in[gi]),
                .flag_out         (flags[gi])
            );
        end
    endgenerate

    // Per-source gating by the individual enable bits only.
    assign gated.comparator_a  = flags.comparator_a  & ctrl0_en[1];
    assign gated.ext_pin_a     = flags.ext_pin_a     & ctrl0_en[2];
    assign gated.ext_pin_b     = flags.ext_pin_b     & ctrl0_en[3];
    assign gated.serial_module = flags.serial_module & ctrl1_en[0];
    assign gated.low_voltage   = flags.low_voltage   & ctrl1_en[1];
    assign gated.adc           = flags.adc           & ctrl1_en[2];
    assign gated.eeprom        = flags.eeprom        & ctrl1_en[3];
    assign gated.periodic_p    = flags.periodic_p    & ctrl2_en[0];
    assign gated.periodic_a    = flags.periodic_a    & ctrl2_en[1];
    assign gated.timer0_p      = flags.timer0_p      & ctrl2_en[2];
    assign gated.timer0_a      = flags.timer0_a      & ctrl2_en[3];
    assign gated.timebase_a    = flags.timebase_a    & ctrl3_en[0];
    assign gated.timebase_b    = flags.timebase_b    & ctrl3_en[1];
    assign gated.comparator_b  = flags.comparator_b  & ctrl3_en[2];
    assign gated.combined      = flags.combined      & ctrl3_en[3];

    // The global enable masks every source at once.
    assign irq_request_out = global_irq_enable ? gated : '0;
    assign irq_pending_out = |irq_request_out;

    // While the return stack is full the core's acknowledge is not honoured.
    assign irq_taken_out = core_ack_in && irq_pending_out && !stack_full_in;

    // Wake on a flag rising; a flag already set by software gives no new edge.
    assign wake_out = |(flags & ~flags_q);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags;
        end
    end

    // Enable bytes; writes to the top bit of control 0 are dropped.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl0_en          <= `IFB_RESET_CTRL;
            ctrl1_en          <= `IFB_RESET_CTRL;
            ctrl2_en          <= `IFB_RESET_CTRL;
            ctrl3_en          <= `IFB_RESET_CTRL;
            global_irq_enable <= 1'b0;
        end else begin
            if (wr0) begin
                ctrl0_en <= wr.data & `IFB_CTRL0_WMASK;
            end
            if (wr1) begin
                ctrl1_en <= wr.data;
            end
            if (wr2) begin
                ctrl2_en <= wr.data;
            end
            if (wr3) begin
                ctrl3_en <= wr.data;
            end
            // Taking an interrupt wins over a same-cycle software write to stop nesting.
            if (irq_taken_out) begin
                global_irq_enable <= 1'b0;
            end else if (wr0) begin
                global_irq_enable <= wr.data[`IFB_GLOBAL_BIT];
            end
        end
    end

    // Read decode.
    wire logic [31:0] core_status;
    assign core_status = {28'h000_0000, stack_full_in, wake_out, irq_pending_out,
                          global_irq_enable};

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        if (rd_addr == `IFB_OFF_CTRL0) begin
            rd_data = {24'h00_0000, ctrl0_val};
        end else if (rd_addr == `IFB_OFF_CTRL1) begin
            rd_data = {24'h00_0000, ctrl1_val};
        end else if (rd_addr == `IFB_OFF_CTRL2) begin
            rd_data = {24'h00_0000, ctrl2_val};
        end else if (rd_addr == `IFB_OFF_CTRL3) begin
            rd_data = {24'h00_0000, ctrl3_val};
        end else if (rd_addr == `IFB_OFF_SOURCES) begin
            rd_data = {17'h0_0000, flags};
        end else if (rd_addr == `IFB_OFF_CORE) begin
            rd_data = core_status;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // The address may be taken before the data, so the decode keeps its own copy of it.
    logic      [11:0] aw_seen;
    wire logic        aw_now;
    wire logic [11:0] aw_sel;
    assign aw_now = s_awvalid_in && s_awready_out;
    assign aw_sel = aw_now ? s_awaddr_in : aw_seen;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_seen <= 12'h000;
        end else if (aw_now) begin
            aw_seen <= s_awaddr_in;
        end
    end

    // Only the four control registers accept writes; index comes from address bits 3:2.
    assign wr_hit = (aw_sel[11:4] == 8'h00) && (aw_sel[1:0] == 2'b00);

    ifb_axil_slave u_bus (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .s_awaddr_in   (s_awaddr_in),
        .s_awvalid_in  (s_awvalid_in),
        .s_awready_out (s_awready_out),
        .s_wdata_in    (s_wdata_in),
        .s_wstrb_in    (s_wstrb_in),
        .s_wvalid_in   (s_wvalid_in),
        .s_wready_out  (s_wready_out),
        .s_bresp_out   (s_bresp_out),
        .s_bvalid_out  (s_bvalid_out),
        .s_bready_in   (s_bready_in),
        .s_araddr_in   (s_araddr_in),
        .s_arvalid_in  (s_arvalid_in),
        .s_arready_out (s_arready_out),
        .s_rdata_out   (s_rdata_out),
        .s_rresp_out   (s_rresp_out),
        .s_rvalid_out  (s_rvalid_out),
        .s_rready_in   (s_rready_in),
        .wr_out        (wr),
        .rd_addr_out   (rd_addr),
        .rd_data_in    (rd_data),
        .rd_hit_in     (rd_hit),
        .wr_hit_in     (wr_hit)
    );
endmodule

// [ifb_map.svh]
// Register offsets, field positions and reset values of the interrupt flag and enable bank.
`ifndef IFB_MAP_SVH
`define IFB_MAP_SVH

`define IFB_OFF_CTRL0        12'h000
`define IFB_OFF_CTRL1        12'h004
`define IFB_OFF_CTRL2        12'h008
`define IFB_OFF_CTRL3        12'h00C
`define IFB_OFF_SOURCES      12'h010
`define IFB_OFF_CORE         12'h014

`define IFB_RESET_CTRL       8'h00
`define IFB_CTRL0_WMASK      8'h7F
`define IFB_GLOBAL_BIT       0
`define IFB_FLAG_LSB         4
`define IFB_ENABLE_LSB       0

`define IFB_CORE_TAKEN_BIT   0
`define IFB_CORE_PENDING_BIT 1
`define IFB_CORE_WAKE_BIT    2
`define IFB_CORE_STKFULL_BIT 3

`define IFB_RESP_OKAY        2'b00
`define IFB_RESP_SLVERR      2'b10

`endif

// [ifb_pkg.sv]
// Types shared by the interrupt flag and enable bank.
package ifb_pkg;

    // Request flags of the fifteen primary sources, one bit each.
    typedef struct packed {
        logic timebase_a;
        logic timebase_b;
        logic comparator_b;
        logic combined;
        logic periodic_p;
        logic periodic_a;
        logic timer0_p;
        logic timer0_a;
        logic serial_module;
        logic low_voltage;
        logic adc;
        logic eeprom;
        logic ext_pin_b;
        logic ext_pin_a;
        logic comparator_a;
    } ifb_src_t;

    // Register write request decoded from the bus.
    typedef struct packed {
        logic       valid;
        logic [1:0] index;
        logic [7:0] data;
    } ifb_wr_t;

    typedef enum logic [1:0] {
        IFB_W_IDLE = 2'b00,
        IFB_W_RESP = 2'b01
    } ifb_wstate_t;

endpackage

// [ifb_flag_cell.sv]
// One request flag with hardware set, software write and service clear.
`timescale 1ns/1ps
module ifb_flag_cell
    import ifb_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic set_in,
    input  wire logic sw_write_in,
    input  wire logic sw_value_in,
    input  wire logic service_clear_in,
    output logic      flag_out
);
    wire logic next_flag;

    // A hardware set wins over any clear in the same cycle so no event is lost.
    assign next_flag = set_in ? 1'b1 :
                       sw_write_in ? sw_value_in :
                       service_clear_in ? 1'b0 : flag_out;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flag_out <= 1'b0;
        end else begin
            flag_out <= next_flag;
        end
    end
endmodule

// [ifb_axil_slave.sv]
// AXI4-Lite slave that turns bus cycles into byte register writes and word reads.
`timescale 1ns/1ps
`include "ifb_map.svh"
module ifb_axil_slave
    import ifb_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [11:0] s_awaddr_in,
    input  wire logic        s_awvalid_in,
    output logic             s_awready_out,
    input  wire logic [31:0] s_wdata_in,
    input  wire logic [3:0]  s_wstrb_in,
    input  wire logic        s_wvalid_in,
    output logic             s_wready_out,
    output logic [1:0]       s_bresp_out,
    output logic             s_bvalid_out,
    input  wire logic        s_bready_in,
    input  wire logic [11:0] s_araddr_in,
    input  wire logic        s_arvalid_in,
    output logic             s_arready_out,
    output logic [31:0]      s_rdata_out,
    output logic [1:0]       s_rresp_out,
    output logic             s_rvalid_out,
    input  wire logic        s_rready_in,
    output ifb_wr_t          wr_out,
    output logic [11:0]      rd_addr_out,
    input  wire logic [31:0] rd_data_in,
    input  wire logic        rd_hit_in,
    input  wire logic        wr_hit_in
);
    ifb_wstate_t wstate;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire logic aw_take;
    wire logic w_take;
    wire logic both;
    wire logic ar_take;

    assign s_awready_out = (wstate == IFB_W_IDLE) && !aw_held;
    assign s_wready_out  = (wstate == IFB_W_IDLE) && !w_held;
    assign aw_take       = s_awvalid_in && s_awready_out;
    assign w_take        = s_wvalid_in && s_wready_out;
    assign both          = (aw_held || aw_take) && (w_held || w_take);
    assign s_arready_out = !s_rvalid_out;
    assign ar_take       = s_arvalid_in && s_arready_out;
    assign rd_addr_out   = s_araddr_in;

    // The write address selects the register, the low data byte is applied when both halves are in and strobe bit 0 is set.
    assign wr_out.valid = both && (wstate == IFB_W_IDLE) && (aw_take ? 1'b1 : aw_held)
                          && (w_take ? s_wstrb_in[0] : w_strb[0]) && wr_hit_in;
    assign wr_out.index = aw_take ? s_awaddr_in[3:2] : aw_addr[3:2];
    assign wr_out.data  = w_take ? s_wdata_in[7:0] : w_data[7:0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wstate       <= IFB_W_IDLE;
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 12'h000;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_bvalid_out <= 1'b0;
            s_bresp_out  <= `IFB_RESP_OKAY;
        end else begin
            case (wstate)
                IFB_W_IDLE: begin
                    if (aw_take) begin
                        aw_addr <= s_awaddr_in;
                    end
                    if (w_take) begin
                        w_data <= s_wdata_in;
                        w_strb <= s_wstrb_in;
                    end
                    if (both) begin
                        aw_held      <= 1'b0;
                        w_held       <= 1'b0;
                        s_bvalid_out <= 1'b1;
                        s_bresp_out  <= wr_hit_in ? `IFB_RESP_OKAY : `IFB_RESP_SLVERR;
                        wstate       <= IFB_W_RESP;
                    end else begin
                        aw_held <= aw_held || aw_take;
                        w_held  <= w_held || w_take;
                    end
                end
                IFB_W_RESP: begin
                    if (s_bready_in) begin
                        s_bvalid_out <= 1'b0;
                        wstate       <= IFB_W_IDLE;
                    end
                end
                default: begin
                    wstate <= IFB_W_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_rvalid_out <= 1'b0;
            s_rdata_out  <= 32'h0000_0000;
            s_rresp_out  <= `IFB_RESP_OKAY;
        end else if (ar_take) begin
            s_rvalid_out <= 1'b1;
            s_rdata_out  <= rd_hit_in ? rd_data_in : 32'h0000_0000;
            s_rresp_out  <= rd_hit_in ? `IFB_RESP_OKAY : `IFB_RESP_SLVERR;
        end else if (s_rready_in) begin
            s_rvalid_out <= 1'b0;
        end
    end
endmodule

// [ifb_bank_props.sv]
// Port assertions for the interrupt flag and enable bank.
`timescale 1ns/1ps
module ifb_bank_props
    import ifb_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        s_awvalid_in,
    input wire logic        s_awready_out,
    input wire logic        s_wvalid_in,
    input wire logic        s_wready_out,
    input wire logic [1:0]  s_bresp_out,
    input wire logic        s_bvalid_out,
    input wire logic        s_bready_in,
    input wire logic        s_arvalid_in,
    input wire logic        s_arready_out,
    input wire logic [31:0] s_rdata_out,
    input wire logic        s_rvalid_out,
    input wire logic        s_rready_in,
    input wire logic        core_ack_in,
    input wire logic        stack_full_in,
    input wire ifb_src_t    irq_request_out,
    input wire logic        irq_pending_out,
    input wire logic        irq_taken_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    pend_or_a: assert property (irq_pending_out == (irq_request_out != '0))
        else $error("pending differs from the request vector");
    taken_gate_a: assert property (irq_taken_out ==
        (core_ack_in && irq_pending_out && !stack_full_in))
        else $error("taken pulse not tied to ack and pending");
    stack_block_a: assert property (stack_full_in |-> !irq_taken_out)
        else $error("interrupt taken while the stack is full");
    global_clear_a: assert property (irq_taken_out |=> irq_request_out == '0)
        else $error("requests still gated through after an interrupt was taken");
    wr_resp_a: assert property (s_awvalid_in && s_awready_out && s_wvalid_in && s_wready_out
        |=> s_bvalid_out)
        else $error("write response missing one cycle after the write");
    rd_resp_a: assert property (s_arvalid_in && s_arready_out |=> s_rvalid_out)
        else $error("read response missing one cycle after the address");
    b_hold_a: assert property (s_bvalid_out && !s_bready_in
        |=> s_bvalid_out && $stable(s_bresp_out))
        else $error("write response dropped before it was taken");
    r_hold_a: assert property (s_rvalid_out && !s_rready_in
        |=> s_rvalid_out && $stable(s_rdata_out))
        else $error("read response dropped before it was taken");
    ar_block_a: assert property (s_rvalid_out |-> !s_arready_out)
        else $error("read address accepted while a read answer stands");
endmodule

bind ifb_bank ifb_bank_props ifb_bank_props_i (.*);

// [ifb_core_model.sv]
// Model of the core and the interrupt sources around the flag bank.
`timescale 1ns/1ps
module ifb_core_model
    import ifb_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire ifb_src_t   fire_in,
    input  wire logic       auto_ack_in,
    input  wire logic [3:0] ack_delay_in,
    input  wire logic       stack_full_in,
    input  wire ifb_src_t   irq_request_in,
    input  wire logic       irq_taken_in,
    output ifb_src_t        src_set_out,
    output logic            core_ack_out,
    output ifb_src_t        core_service_out,
    output logic            stack_full_out
);
    logic [3:0] wait_cnt;
    ifb_src_t   next_service;

    assign src_set_out    = fire_in;
    assign stack_full_out = stack_full_in;
    // Lowest source is serviced; the vector priority order is not modelled.
    assign next_service   = ifb_src_t'(irq_request_in & (~irq_request_in + 15'h0001));

    // The ack stands until the bank really takes it, so a full stack only delays it.
    always_ff @(posedge clk_in) begin
        core_service_out <= '0;
        if (rst_in || !auto_ack_in) begin
            wait_cnt     <= '0;
            core_ack_out <= 1'b0;
        end else if (irq_taken_in) begin
            wait_cnt         <= '0;
            core_ack_out     <= 1'b0;
            core_service_out <= next_service;
        end else if (irq_request_in != '0) begin
            if (wait_cnt == ack_delay_in)
                core_ack_out <= 1'b1;
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

// [interrupt_flag_enable_bank_bench.sv]
// Self-checking bench for the interrupt flag and enable bank.
`timescale 1ns/1ps
`include "ifb_map.svh"
module interrupt_flag_enable_bank_bench
    import ifb_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] rdata, rdat;
    ifb_src_t    fire = '0;
    ifb_src_t    src_set, service, irq_req;
    logic        auto_ack = 1'b0;
    logic        stk_full = 1'b0;
    logic        core_ack, stack_full, pending, taken, wake;
    int          n_fail = 0;
    int          tests_run = 0;
    int          wake_cnt = 0;

    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) if (wake) wake_cnt <= wake_cnt + 1;

    ifb_bank ifb_bank_i (
        .clk_in(clk_in), .rst_in(rst_in),
        .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready),
        .s_wdata_in(wdata), .s_wstrb_in(4'hF), .s_wvalid_in(wvalid), .s_wready_out(wready),
        .s_bresp_out(bresp), .s_bvalid_out(bvalid), .s_bready_in(bready),
        .s_araddr_in(araddr), .s_arvalid_in(arvalid), .s_arready_out(arready),
        .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid), .s_rready_in(rready),
        .src_set_in(src_set), .core_ack_in(core_ack), .core_service_in(service),
        .stack_full_in(stack_full), .irq_request_out(irq_req), .irq_pending_out(pending),
        .irq_taken_out(taken), .wake_out(wake)
    );

    ifb_core_model ifb_core_model_i (
        .clk_in(clk_in), .rst_in(rst_in), .fire_in(fire), .auto_ack_in(auto_ack),
        .ack_delay_in(4'h5), .stack_full_in(stk_full), .irq_request_in(irq_req),
        .irq_taken_in(taken), .src_set_out(src_set), .core_ack_out(core_ack),
        .core_service_out(service), .stack_full_out(stack_full)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bound(input int n);
        if (n >= 50) begin
            n_fail++;
            $display("unexpected at %0t: wait ran out", $time);
            print_verdict();
        end
    endtask

    task automatic pulse(input ifb_src_t v);
        @(posedge clk_in);
        fire <= v;
        @(posedge clk_in);
        fire <= '0;
    endtask

    // One bus access; the answer is left in rdat and rsp. Ready is raised only
    // after valid is seen, so every answer is made to stand for a cycle.
    task automatic acc(input bit w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_in);
        if (w) begin
            awaddr <= a;
            awvalid <= 1'b1;
            wdata <= {24'h00_0000, d};
            wvalid <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
        end
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if ((bvalid && bready) || (rvalid && rready)) break;
            if (bvalid) bready <= 1'b1;
            if (rvalid) rready <= 1'b1;
        end
        bound(n);
        rsp = w ? bresp : rresp;
        rdat = rdata;
        bready <= 1'b0;
        rready <= 1'b0;
    endtask

    task automatic t_reset();
        int r;
        for (r = 0; r < 4; r++) begin
            acc(1'b0, 12'(r * 4), 8'h00);
            chk(rdat, 32'h0000_0000);
        end
        acc(1'b0, 12'h020, 8'h00);
        chk(32'(rsp), 32'(`IFB_RESP_SLVERR));
        acc(1'b1, 12'h040, 8'hFF);
        chk(32'(rsp), 32'(`IFB_RESP_SLVERR));
        acc(1'b0, 12'h000, 8'h00);
        chk(rdat, 32'h0000_0000);
        acc(1'b1, 12'h000, 8'hFF);
        acc(1'b0, 12'h000, 8'h00);
        chk(rdat, 32'h0000_007F);
        acc(1'b1, 12'h000, 8'h00);
        $display("test reset and reserved bit done");
    endtask

    task automatic t_sources();
        int i, r, b;
        logic [7:0]  fe, g;
        logic [11:0] a;
        for (i = 0; i < 15; i++) begin
            r = i < 3 ? 0 : (i < 7 ? 1 : (i < 11 ? 2 : 3));
            b = i < 3 ? i + 4 : 7 - (i - 3) % 4;
            a = 12'(r * 4);
            fe = 8'(1 << b) | 8'(1 << (r == 0 ? b - 3 : b - 4));
            g = r == 0 ? fe : 8'h00;
            pulse(ifb_src_t'(1 << i));
            acc(1'b0, a, 8'h00);
            chk(rdat, 32'(1 << b));
            acc(1'b0, `IFB_OFF_SOURCES, 8'h00);
            chk(rdat, 32'(1 << i));
            if (r != 0) acc(1'b1, a, fe);
            acc(1'b1, 12'h000, g);
            chk(32'(irq_req), 32'h0000_0000);
            acc(1'b1, 12'h000, g | 8'h01);
            chk(32'(irq_req), 32'(1 << i));
            acc(1'b1, a, 8'h00);
            acc(1'b1, 12'h000, 8'h00);
            acc(1'b0, `IFB_OFF_SOURCES, 8'h00);
            chk(rdat, 32'h0000_0000);
        end
        $display("test source map done");
    endtask

    task automatic t_taken();
        int n;
        acc(1'b1, 12'h004, 8'h08);
        stk_full <= 1'b1;
        auto_ack <= 1'b1;
        acc(1'b1, 12'h000, 8'h01);
        pulse(ifb_src_t'(1 << 3));
        repeat (20) @(posedge clk_in);
        chk(32'(core_ack & pending), 32'h0000_0001);
        acc(1'b0, `IFB_OFF_CORE, 8'h00);
        chk(rdat, 32'h0000_000B);
        stk_full <= 1'b0;
        for (n = 0; n < 50 && taken !== 1'b1; n++) @(posedge clk_in);
        bound(n);
        pulse(ifb_src_t'(1 << 12));
        acc(1'b0, 12'h000, 8'h00);
        chk(rdat, 32'h0000_0000);
        acc(1'b0, `IFB_OFF_SOURCES, 8'h00);
        chk(rdat, 32'(1 << 12));
        auto_ack <= 1'b0;
        acc(1'b1, 12'h00C, 8'h00);
        acc(1'b1, 12'h004, 8'h00);
        $display("test interrupt taken done");
    endtask

    task automatic t_wake();
        int w0;
        w0 = wake_cnt;
        pulse(ifb_src_t'(1 << 5));
        repeat (4) @(posedge clk_in);
        chk(32'(wake_cnt - w0), 32'h0000_0001);
        acc(1'b1, 12'h004, 8'h10);
        repeat (4) @(posedge clk_in);
        w0 = wake_cnt;
        pulse(ifb_src_t'(1 << 6));
        repeat (4) @(posedge clk_in);
        chk(32'(wake_cnt - w0), 32'h0000_0000);
        acc(1'b1, 12'h004, 8'h00);
        $display("test wake done");
    endtask

    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_sources();
        t_taken();
        t_wake();
        print_verdict();
    end
endmodule
